// ===== hw/rtt_pkg.sv
/*
 * shared constants and encodings of the relay transient test controller.
 * assumes a 25 MHz controller clock and a 1 ms housekeeping tick.
 */
package rtt_pkg;

  // clock and tick timing
  localparam int unsigned CLK_NS = 40;          // clock period in ns
  localparam int unsigned TICK_NS = 1000000;    // housekeeping tick, 1 ms
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;

  // durations in ms ticks
  localparam logic [16:0] SEQ_LONG_MS = 17'd120000;  // 120 s
  localparam logic [16:0] SEQ_SHORT_MS = 17'd20000;  // 20 s
  localparam logic [16:0] SEQ_MID_MS = 17'd60000;    // 60 s
  localparam logic [10:0] HOLD_MS = 11'd2000;        // 2 s hold
  localparam logic [9:0] SEC_MS = 10'd1000;          // ticks per second
  localparam logic [8:0] FLASH_MS = 9'd500;          // lamp blink half
  localparam logic [6:0] PROBE_MS = 7'd100;          // probe burst period
  localparam logic [3:0] RELAY_HALF_MS = 4'd12;      // ~25 ms relay cycle
  localparam logic [4:0] BURST_LEN = 5'd16;          // probe window, cycles

  // lifetime thresholds in seconds
  localparam logic [18:0] LIFE_FLASH_S = 19'd324000; // 90 h
  localparam logic [18:0] LIFE_STOP_S = 19'd360000;  // 100 h

  // register byte offsets (low address bits)
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_HOURS = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;

  // status field positions
  localparam int STAT_TEST = 0;     // [1:0]
  localparam int STAT_PULSE = 2;    // [4:2]
  localparam int STAT_MODE = 5;     // [6:5]
  localparam int STAT_STATE = 7;    // [8:7]
  localparam int STAT_EXT = 9;
  localparam int STAT_POWER = 10;
  localparam int STAT_WEAR = 11;
  localparam int CTRL_CLR = 0;      // write 1 clears lifetime counter

  // button indices
  localparam int B_ID = 0;
  localparam int B_PULSE = 1;
  localparam int B_MODE = 2;
  localparam int B_START = 3;
  localparam int B_POWER = 4;

  typedef enum logic [1:0] {
    TEST_RADIATED = 2'b00,
    TEST_CONDUCTED = 2'b01,
    TEST_DROPOUT = 2'b10
  } test_t;

  typedef enum logic [2:0] {
    P_TYPE_ONE = 3'b000,
    P_TYPE_TWO = 3'b001,
    P_TWO_C1 = 3'b010,
    P_THREE_C2 = 3'b011,
    P_TYPE_THREE = 3'b100,
    P_DROPOUT = 3'b101
  } pulse_t;

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_ONE = 2'b01,
    MODE_TWO = 2'b10,
    MODE_THREE = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_SEQ = 2'b01,
    ST_ENDLESS = 2'b10,
    ST_WORN = 2'b11
  } state_t;

endpackage : rtt_pkg

// ===== hw/relay_transient_test_controller.sv
/*
 * front-panel controller of a relay transient test box: selection,
 * sequence/endless runs, unit power, trigger probing, lifetime count,
 * with an ahb-lite register slave.
 * assumes one 25 MHz clock, asynchronous active-low reset, active-high
 * button pins and a single ahb-lite master.
 */
// Contract
// - selections change only while stopped
// - each press steps selection, wrapping around
// - tests rotate radiated, conducted, dropout
// - only pulses valid for the test
// - only modes valid for test and pulse
// - start release powers unit, starts test
// - sequence lamp lit, ends after duration
// - 120 s or 20 s conducted durations
// - 60 s radiated and dropout durations
// - 2 s hold starts endless run
// - start/stop press ends any run
// - external trigger forces endless run
// - stop restores power held before start
// - power press stops test, removes power
// - conducted: power toggles, second press stops
// - power button ignored outside conducted test
// - stopped: three short probe pulses, detect bridge
// - internal trigger drives relay timing
// - trigger input accepted only while running
// - lifetime counts only in endless runs
// - exactly one run lamp while running
// - 90 h flash, 100 h steady, stop
`timescale 1ns/1ns
module relay_transient_test_controller #(
  parameter int unsigned TICK_CYCLES = rtt_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // panel buttons, high while pressed
  input wire logic [4:0] btn_pins,
  // trigger connectors and drives
  input wire logic trig_in_pin,
  output logic trig_out,
  output logic relay_drive,
  output logic uut_power_en,
  // lamps
  output logic [2:0] lamp_test,
  output logic [5:0] lamp_pulse,
  output logic [3:0] lamp_mode,
  output logic lamp_seq,
  output logic lamp_endless,
  output logic lamp_ext_trig,
  output logic relay_wearout_lamp
);
  import rtt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // selection tables
  function automatic pulse_t first_pulse(input test_t t);
    case (t)
      TEST_CONDUCTED: first_pulse = P_TYPE_ONE;
      TEST_DROPOUT: first_pulse = P_DROPOUT;
      default: first_pulse = P_TYPE_TWO;
    endcase
  endfunction : first_pulse

  function automatic pulse_t next_pulse(input test_t t, input pulse_t p);
    next_pulse = first_pulse(t); // wrap by default
    if (t == TEST_CONDUCTED && p != P_THREE_C2)
      next_pulse = pulse_t'(p + 3'h1);
    if (t == TEST_RADIATED && p == P_TYPE_TWO)
      next_pulse = P_TYPE_THREE;
  endfunction : next_pulse

  function automatic mode_t first_mode(input test_t t, input pulse_t p);
    if (t == TEST_DROPOUT)
      first_mode = MODE_NONE;
    else if (t == TEST_CONDUCTED && (p == P_TYPE_ONE || p == P_TYPE_TWO))
      first_mode = MODE_ONE;
    else
      first_mode = MODE_TWO;
  endfunction : first_mode

  function automatic mode_t next_mode(input test_t t, input pulse_t p,
                                      input mode_t m);
    next_mode = first_mode(t, p);
    if (t == TEST_CONDUCTED && p == P_TYPE_ONE && m == MODE_ONE)
      next_mode = MODE_TWO;
    if (next_mode == MODE_TWO && m == MODE_TWO && p != P_TYPE_ONE)
      next_mode = MODE_THREE;
  endfunction : next_mode

  // sequence length in ms ticks
  function automatic logic [16:0] seq_len(input test_t t, input pulse_t p,
                                          input mode_t m);
    if (t == TEST_CONDUCTED)
      seq_len = (m == MODE_ONE) ? SEQ_LONG_MS : SEQ_SHORT_MS;
    else
      seq_len = SEQ_MID_MS;
  endfunction : seq_len

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; buttons read at the second stage, trigger at the second and third
  logic [4:0] btn_s1_q, btn_s2_q;
  logic trig_s1_q, trig_s2_q, trig_s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btn_s1_q <= 5'h00;
      btn_s2_q <= 5'h00;
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      btn_s1_q <= btn_pins;
      btn_s2_q <= btn_s1_q;
      trig_s1_q <= trig_in_pin;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 1 ms tick and button debounce
  // sampling once per ms hides contact bounce shorter than a tick
  logic [14:0] tick_q, tick_d;
  logic tick;
  logic [4:0] db_q, db_d, dbp_q, press, rel;

  assign tick = (tick_q == 15'(TICK_CYCLES - 1));
  assign press = db_q & ~dbp_q;
  assign rel = ~db_q & dbp_q;

  always_comb begin
    tick_d = tick ? 15'h0000 : tick_q + 15'h0001;
    db_d = tick ? btn_s2_q : db_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 15'h0000;
      db_q <= 5'h00;
      dbp_q <= 5'h00;
    end else begin
      tick_q <= tick_d;
      db_q <= db_d;
      dbp_q <= db_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, read data captured at address phase
  logic wr_pend_q, wr_pend_d;
  logic [3:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_d;
  logic [31:0] status_w;
  logic clr_hours;
  logic addr_ph;

  assign addr_ph = hsel & htrans[1] & hready;
  assign clr_hours = wr_pend_q & (wr_addr_q == ADDR_CTRL) & hwdata[CTRL_CLR];

  ////////////////////////////////////////////////////////////////////////
  // controller state
  state_t state_q, state_d;
  test_t test_q, test_d;
  pulse_t pulse_q, pulse_d;
  mode_t mode_q, mode_d;
  logic power_q, power_d;       // unit power switch
  logic pwr_before_q, pwr_before_d;
  logic armed_q, armed_d;       // start press seen while stopped
  logic [10:0] hold_q, hold_d;
  logic [16:0] dur_q, dur_d;
  logic [9:0] sec_q, sec_d;
  logic [18:0] life_q, life_d;  // lifetime in seconds
  logic [8:0] flash_q, flash_d;
  logic blink_q, blink_d;
  logic [6:0] probe_q, probe_d;
  logic [4:0] burst_q, burst_d;
  logic [1:0] edges_q, edges_d;
  logic ext_q, ext_d;
  logic [3:0] rly_q, rly_d;
  logic trig_q, trig_d;
  logic run, start_now, stop_now;

  assign run = (state_q == ST_SEQ) || (state_q == ST_ENDLESS);

  always_comb begin
    state_d = state_q;
    test_d = test_q;
    pulse_d = pulse_q;
    mode_d = mode_q;
    power_d = power_q;
    pwr_before_d = pwr_before_q;
    armed_d = armed_q;
    hold_d = hold_q;
    dur_d = dur_q;
    sec_d = sec_q;
    life_d = life_q;
    start_now = 1'b0;
    stop_now = 1'b0;
    // selections, stopped only
    if (state_q == ST_STOP) begin
      if (press[B_ID]) begin
        test_d = (test_q == TEST_DROPOUT) ? TEST_RADIATED
                                          : test_t'(test_q + 2'h1);
        pulse_d = first_pulse(test_d);
        mode_d = first_mode(test_d, pulse_d);
      end else if (press[B_PULSE]) begin
        pulse_d = next_pulse(test_q, pulse_q);
        mode_d = first_mode(test_q, pulse_d);
      end else if (press[B_MODE]) begin
        mode_d = next_mode(test_q, pulse_q, mode_q);
      end
    end
    // start: hold for endless, release for sequence
    if (state_q == ST_STOP) begin
      if (press[B_START]) begin
        armed_d = 1'b1;
        hold_d = 11'h000;
      end else if (armed_q && db_q[B_START] && tick) begin
        hold_d = hold_q + 11'h001;
        if (hold_q == HOLD_MS - 11'h001) begin
          armed_d = 1'b0;
          start_now = 1'b1;
          state_d = ST_ENDLESS;
        end
      end else if (armed_q && rel[B_START]) begin
        armed_d = 1'b0;
        start_now = 1'b1;
        state_d = ext_q ? ST_ENDLESS : ST_SEQ;
      end
    end
    if (start_now) begin
      pwr_before_d = power_q;
      power_d = 1'b1;
      dur_d = 17'h00000;
    end
    // sequence timing
    if (state_q == ST_SEQ && tick) begin
      dur_d = dur_q + 17'h00001;
      if (dur_q == seq_len(test_q, pulse_q, mode_q) - 17'h00001)
        stop_now = 1'b1;
    end
    if (run && press[B_START])
      stop_now = 1'b1;
    if (stop_now) begin
      state_d = ST_STOP;
      armed_d = 1'b0;
      power_d = pwr_before_q;
    end
    // power button acts only on the conducted test
    if (test_q == TEST_CONDUCTED && press[B_POWER]) begin
      if (run) begin
        state_d = ST_STOP;
        armed_d = 1'b0;
        power_d = 1'b0;
      end else if (state_q == ST_STOP) begin
        power_d = ~power_q;
      end
    end
    // lifetime accumulates only in endless runs
    if (state_q == ST_ENDLESS && tick) begin
      sec_d = (sec_q == SEC_MS - 10'h001) ? 10'h000 : sec_q + 10'h001;
      if (sec_q == SEC_MS - 10'h001)
        life_d = life_q + 19'h00001;
    end
    if (clr_hours) begin
      life_d = 19'h00000;
      sec_d = 10'h000;
      if (state_q == ST_WORN)
        state_d = ST_STOP;
    end else if (life_q >= LIFE_STOP_S) begin
      state_d = ST_WORN;
      power_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger probing, relay timing, lamp blink
  always_comb begin
    probe_d = probe_q;
    burst_d = burst_q;
    edges_d = edges_q;
    ext_d = ext_q;
    rly_d = rly_q;
    trig_d = 1'b0;
    flash_d = flash_q;
    blink_d = blink_q;
    if (state_q == ST_STOP) begin
      rly_d = 4'h0;
      if (burst_q != 5'h00) begin
        // pulses one cycle wide in cycles 1, 3 and 5 of the window
        burst_d = burst_q + 5'h01;
        trig_d = burst_d[0] & (burst_d < 5'h06);
        if (trig_s2_q && !trig_s3_q && edges_q != 2'h3)
          edges_d = edges_q + 2'h1;
        if (burst_q == BURST_LEN) begin
          burst_d = 5'h00;
          ext_d = (edges_d != 2'h3);
        end
      end else if (tick) begin
        probe_d = (probe_q == PROBE_MS - 7'h01) ? 7'h00 : probe_q + 7'h01;
        if (probe_q == PROBE_MS - 7'h01) begin
          burst_d = 5'h01;
          edges_d = 2'h0;
          trig_d = 1'b1;
        end
      end
    end else begin
      burst_d = 5'h00;
      trig_d = trig_q;
      if (run && !ext_q && tick) begin
        rly_d = (rly_q == RELAY_HALF_MS - 4'h1) ? 4'h0 : rly_q + 4'h1;
        if (rly_q == RELAY_HALF_MS - 4'h1)
          trig_d = ~trig_q;
      end
      // a stop drops the relay level so the first probe pulse stays short
      if (!run || state_d == ST_STOP)
        trig_d = 1'b0;
    end
    if (tick) begin
      flash_d = (flash_q == FLASH_MS - 9'h001) ? 9'h000 : flash_q + 9'h001;
      if (flash_q == FLASH_MS - 9'h001)
        blink_d = ~blink_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus next values
  always_comb begin
    status_w = 32'h00000000;
    status_w[STAT_TEST +: 2] = test_q;
    status_w[STAT_PULSE +: 3] = pulse_q;
    status_w[STAT_MODE +: 2] = mode_q;
    status_w[STAT_STATE +: 2] = state_q;
    status_w[STAT_EXT] = ext_q;
    status_w[STAT_POWER] = power_q;
    status_w[STAT_WEAR] = (life_q >= LIFE_FLASH_S);
    wr_pend_d = addr_ph & hwrite;
    wr_addr_d = haddr[3:0];
    rdata_d = hrdata;
    // unmapped addresses read as zero
    if (addr_ph && !hwrite) begin
      case (haddr[3:0])
        ADDR_STATUS: rdata_d = status_w;
        ADDR_HOURS: rdata_d = {13'h0000, life_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register all state and outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_STOP;
      test_q <= TEST_RADIATED;
      pulse_q <= P_TYPE_TWO;
      mode_q <= MODE_TWO;
      power_q <= 1'b0;
      pwr_before_q <= 1'b0;
      armed_q <= 1'b0;
      hold_q <= 11'h000;
      dur_q <= 17'h00000;
      sec_q <= 10'h000;
      life_q <= 19'h00000;
      flash_q <= 9'h000;
      blink_q <= 1'b0;
      probe_q <= 7'h00;
      burst_q <= 5'h00;
      edges_q <= 2'h0;
      ext_q <= 1'b0;
      rly_q <= 4'h0;
      trig_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      relay_drive <= 1'b0;
      lamp_test <= 3'h0;
      lamp_pulse <= 6'h00;
      lamp_mode <= 4'h0;
      lamp_seq <= 1'b0;
      lamp_endless <= 1'b0;
      lamp_ext_trig <= 1'b0;
      relay_wearout_lamp <= 1'b0;
    end else begin
      state_q <= state_d;
      test_q <= test_d;
      pulse_q <= pulse_d;
      mode_q <= mode_d;
      power_q <= power_d;
      pwr_before_q <= pwr_before_d;
      armed_q <= armed_d;
      hold_q <= hold_d;
      dur_q <= dur_d;
      sec_q <= sec_d;
      life_q <= life_d;
      flash_q <= flash_d;
      blink_q <= blink_d;
      probe_q <= probe_d;
      burst_q <= burst_d;
      edges_q <= edges_d;
      ext_q <= ext_d;
      rly_q <= rly_d;
      trig_q <= trig_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata <= rdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      relay_drive <= run & trig_s2_q;
      lamp_test <= 3'h1 << test_q;
      lamp_pulse <= 6'h01 << pulse_q;
      lamp_mode <= 4'h1 << mode_q;
      lamp_seq <= (state_q == ST_SEQ);
      lamp_endless <= (state_q == ST_ENDLESS);
      lamp_ext_trig <= ext_q;
      relay_wearout_lamp <= (state_q == ST_WORN) |
                            ((life_q >= LIFE_FLASH_S) & blink_q);
    end
  end

  assign trig_out = trig_q;
  assign uut_power_en = power_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_sel_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    run |=> $stable(test_q) && $stable(pulse_q))
    else $error("selection changed during a run");
  chk_test_rotate: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_STOP && press[B_ID] && test_q == TEST_DROPOUT
    |=> test_q == TEST_RADIATED && pulse_q == P_TYPE_TWO)
    else $error("test selection did not wrap");
  chk_lamp_one: assert property (@(posedge hclk) disable iff (!hresetn)
    run |=> lamp_seq != lamp_endless)
    else $error("run lamps not exclusive");
  chk_ext_endless: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_q && state_q == ST_STOP |=> state_q != ST_SEQ)
    else $error("sequence started with external trigger");
  chk_start_power: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_STOP ##1 run |-> power_q)
    else $error("run started without unit power");
  chk_power_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    run && test_q == TEST_CONDUCTED && press[B_POWER] && !clr_hours
    |=> state_q == ST_STOP && !power_q ##1 !uut_power_en)
    else $error("power press did not stop and cut power");
  chk_power_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_STOP && test_q != TEST_CONDUCTED && !armed_q
    |=> $stable(power_q))
    else $error("power changed outside conducted test");
  chk_life_endless: assert property (@(posedge hclk) disable iff (!hresetn)
    life_q != $past(life_q) && !$past(clr_hours)
    |-> $past(state_q) == ST_ENDLESS)
    else $error("lifetime counted outside endless run");
  chk_worn_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    life_q >= LIFE_STOP_S && !clr_hours
    |=> state_q == ST_WORN && !power_q)
    else $error("worn relays did not stop the box");
  chk_probe_width: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_STOP && state_d == ST_STOP && trig_q |=> !trig_q)
    else $error("probe pulse longer than one cycle");

endmodule : relay_transient_test_controller

// ===== dv/trigger_bridge_model.sv
/*
 * far-side model: trigger bridge between trigger out and trigger in,
 * or an external relay trigger generator when the bridge is pulled.
 * assumes the controller clock; the bench picks the source.
 */
`timescale 1ns/1ns
module trigger_bridge_model #(
  parameter int GEN_HALF = 24 // generator half period in cycles
) (
  // clock
  input wire logic hclk,
  // source choice
  input wire logic bridge_on,
  input wire logic gen_en,
  // trigger connectors
  input wire logic trig_out,
  output logic trig_in_pin
);
  int cnt_q = 0; // generator phase count
  logic gen_q = 1'b0; // generator level
  ////////////////////////////////////////////////////////////////////////
  // external generator, slower than a probe window so it never fakes one
  always_ff @(posedge hclk) begin
    if (!gen_en || cnt_q == GEN_HALF - 1) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
    if (!gen_en) begin
      gen_q <= 1'b0;
    end else if (cnt_q == GEN_HALF - 1) begin
      gen_q <= ~gen_q;
    end
  end
  // bridge loops probes back; without it only the generator reaches in
  assign trig_in_pin = bridge_on ? trig_out : gen_q;
endmodule : trigger_bridge_model

// ===== dv/testbench.sv
/*
 * self-checking bench of the relay transient test controller.
 * assumes a short housekeeping tick (T cycles) and the bridge model.
 */
`timescale 1ns/1ns
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value at %0t: got %0h want %0h", $time, got, exp); \
  end \
end
module testbench;
  import rtt_pkg::*;
  localparam int T = 2; // cycles per tick in this run
  localparam int SEQ_CYC = int'(SEQ_SHORT_MS) * T; // short run length
  typedef struct {int b; test_t t; pulse_t p; mode_t m;} step_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] btn_pins = 5'h0;
  logic bridge_on = 1'b1; // start with the bridge fitted
  logic gen_en = 1'b0;
  logic hreadyout, hresp, trig_in_pin, trig_out, relay_drive;
  logic uut_power_en, lamp_seq, lamp_endless, lamp_ext_trig;
  logic relay_wearout_lamp;
  logic [31:0] hrdata, d;
  logic [2:0] lamp_test;
  logic [5:0] lamp_pulse;
  logic [3:0] lamp_mode;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0; // cycle count for timeout and run timing
  int n, t0;
  step_t steps [19]; // button, expected selection after it
  ////////////////////////////////////////////////////////////////////////
  always #20 hclk = ~hclk;
  relay_transient_test_controller #(
    .TICK_CYCLES(T)
  ) u_relay_transient_test_controller (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .btn_pins(btn_pins), .trig_in_pin(trig_in_pin),
    .trig_out(trig_out), .relay_drive(relay_drive),
    .uut_power_en(uut_power_en), .lamp_test(lamp_test),
    .lamp_pulse(lamp_pulse), .lamp_mode(lamp_mode), .lamp_seq(lamp_seq),
    .lamp_endless(lamp_endless), .lamp_ext_trig(lamp_ext_trig),
    .relay_wearout_lamp(relay_wearout_lamp));
  trigger_bridge_model u_trigger_bridge_model (.hclk(hclk),
    .bridge_on(bridge_on), .gen_en(gen_en), .trig_out(trig_out),
    .trig_in_pin(trig_in_pin));
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, well above the expected run of about 50000 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // one single-word transfer; entered just after a rising edge
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // hold a button for len cycles, then let the debounce settle
  task press(input int b, input int len);
    btn_pins[b] <= 1'b1;
    repeat (len) @(posedge hclk);
    btn_pins[b] <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask : press
  // status register against selection, run state and unit power
  task chk_st(input test_t t, input pulse_t p, input mode_t m,
              input state_t s, input logic pw);
    ahb(1'b0, {28'h0, ADDR_STATUS}, 32'h0, d);
    `CHK({d[10], d[8:0]}, {pw, s, m, p, t})
  endtask : chk_st
  // rising edges of trig_out (sel 0) or relay_drive (sel 1)
  task rises(input int sel, input int len, output int c);
    logic p;
    logic v;
    c = 0;
    p = 1'b0;
    repeat (len) begin
      @(posedge hclk);
      v = sel ? relay_drive : trig_out;
      if (v === 1'b1 && p !== 1'b1) c++;
      p = v;
    end
  endtask : rises
  ////////////////////////////////////////////////////////////////////////
  initial begin
    steps = '{'{B_PULSE, TEST_RADIATED, P_TYPE_THREE, MODE_TWO},
      '{B_PULSE, TEST_RADIATED, P_TYPE_TWO, MODE_TWO},
      '{B_MODE, TEST_RADIATED, P_TYPE_TWO, MODE_THREE},
      '{B_MODE, TEST_RADIATED, P_TYPE_TWO, MODE_TWO},
      '{B_POWER, TEST_RADIATED, P_TYPE_TWO, MODE_TWO},
      '{B_ID, TEST_CONDUCTED, P_TYPE_ONE, MODE_ONE},
      '{B_MODE, TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO},
      '{B_MODE, TEST_CONDUCTED, P_TYPE_ONE, MODE_ONE},
      '{B_PULSE, TEST_CONDUCTED, P_TYPE_TWO, MODE_ONE},
      '{B_MODE, TEST_CONDUCTED, P_TYPE_TWO, MODE_ONE},
      '{B_PULSE, TEST_CONDUCTED, P_TWO_C1, MODE_TWO},
      '{B_MODE, TEST_CONDUCTED, P_TWO_C1, MODE_THREE},
      '{B_PULSE, TEST_CONDUCTED, P_THREE_C2, MODE_TWO},
      '{B_PULSE, TEST_CONDUCTED, P_TYPE_ONE, MODE_ONE},
      '{B_ID, TEST_DROPOUT, P_DROPOUT, MODE_NONE},
      '{B_POWER, TEST_DROPOUT, P_DROPOUT, MODE_NONE},
      '{B_ID, TEST_RADIATED, P_TYPE_TWO, MODE_TWO},
      '{B_ID, TEST_CONDUCTED, P_TYPE_ONE, MODE_ONE},
      '{B_MODE, TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO}};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // defaults after reset, unmapped read, probe bursts while stopped
    chk_st(TEST_RADIATED, P_TYPE_TWO, MODE_TWO, ST_STOP, 1'b0);
    `CHK({lamp_test, lamp_pulse, lamp_mode}, 13'h0424)
    `CHK({hresp, relay_wearout_lamp, uut_power_en}, 3'b000)
    ahb(1'b0, 32'hc, 32'h0, d);
    `CHK(d, 32'h0)
    // second burst lands 100 ticks after the first window closes
    rises(0, 250 * T, n);
    `CHK(n, 6)
    `CHK(lamp_ext_trig, 1'b0)
    // selection walk: steps, wraps, refused power presses
    foreach (steps[i]) begin
      press(steps[i].b, 8);
      chk_st(steps[i].t, steps[i].p, steps[i].m, ST_STOP, 1'b0);
      `CHK(lamp_test, 3'h1 << steps[i].t)
      `CHK(lamp_pulse, 6'h01 << steps[i].p)
      `CHK(lamp_mode, 4'h1 << steps[i].m)
    end
    // timed run, selection locked, internal relay trigger
    press(B_START, 8);
    t0 = cyc;
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_SEQ, 1'b1);
    `CHK(uut_power_en, 1'b1)
    `CHK({lamp_seq, lamp_endless}, 2'b10)
    press(B_ID, 8);
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_SEQ, 1'b1);
    rises(1, 60 * T, n);
    `CHK(n > 0, 1'b1)
    while (cyc < t0 + SEQ_CYC - 200) @(posedge hclk);
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_SEQ, 1'b1);
    repeat (400) @(posedge hclk);
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_STOP, 1'b0);
    `CHK(lamp_seq, 1'b0)
    ahb(1'b0, {28'h0, ADDR_HOURS}, 32'h0, d);
    `CHK(d, 32'h0)
    // stop by start keeps power that was on before
    press(B_POWER, 8);
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_STOP, 1'b1);
    press(B_START, 8);
    press(B_START, 8);
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_STOP, 1'b1);
    // power press mid-run stops and removes power
    press(B_START, 8);
    press(B_POWER, 8);
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_STOP, 1'b0);
    `CHK(uut_power_en, 1'b0)
    // long hold starts an endless run, which counts lifetime
    press(B_START, 2000 * T + 20);
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_ENDLESS, 1'b1);
    `CHK({lamp_seq, lamp_endless}, 2'b01)
    repeat (1250 * T) @(posedge hclk);
    ahb(1'b0, {28'h0, ADDR_HOURS}, 32'h0, d);
    `CHK(d, 32'h1)
    press(B_START, 8);
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_STOP, 1'b0);
    ahb(1'b1, {28'h0, ADDR_CTRL}, 32'h1, d);
    ahb(1'b0, {28'h0, ADDR_HOURS}, 32'h0, d);
    `CHK(d, 32'h0)
    // bridge pulled: external source, forced endless, gated drive
    bridge_on <= 1'b0;
    gen_en <= 1'b1;
    repeat (300 * T) @(posedge hclk);
    `CHK(lamp_ext_trig, 1'b1)
    rises(1, 100 * T, n);
    `CHK(n, 0)
    press(B_START, 8);
    chk_st(TEST_CONDUCTED, P_TYPE_ONE, MODE_TWO, ST_ENDLESS, 1'b1);
    `CHK(d[9], 1'b1)
    rises(1, 100 * T, n);
    `CHK(n > 0, 1'b1)
    press(B_START, 8);
    tally_and_finish();
  end
endmodule : testbench
